// ==== hdl/rtcsa_core.sv ====
// Real-time clock and calendar with two alarms behind a two-wire serial slave.
// Assumes SCL/SDA/crystal/backup pins are asynchronous and that the testbench
// resolves the open-drain SDA and interrupt wires from the enables.
`timescale 1ns/100ps

module rtcsa_core #(
    parameter int P_NV_WRITE_CYCLES = rtcsa_pkg::NV_WRITE_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_link,
    input wire logic i_scl,
    input wire logic i_sda_i,
    input wire logic i_xtal,
    input wire logic i_on_backup,
    input wire logic i_irq_en,
    input wire logic i_alarm_repeat,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_irq_o,
    output logic o_irq_oe
);
    import rtcsa_pkg::*;

    localparam int NVW = $clog2(P_NV_WRITE_CYCLES + 1);
    localparam logic [NVW-1:0] NV_LAST = NVW'(P_NV_WRITE_CYCLES - 1);

    // Crossing registers; each first stage feeds only the next stage.
    logic [2:0] xs_q, cts_q, sqs_q, cls_q;
    logic [1:0] bs_q;
    logic [2:0] scl_q, sda_q, nvs_q;
    logic [1:0] lrst_q, sak_q;

    // System-domain state.
    logic [14:0] pre_q, pre_d;
    rtcsa_bank_t tm_q, tm_d;
    rtcsa_bank_t al_q [2];
    rtcsa_bank_t al_d [2];
    logic [1:0] arm_q, arm_d, flag_q, flag_d;
    logic rtcf_q, rtcf_d, tick_q, tick_d, nvb_q, nvb_d, sack_q, sack_d;
    logic irq_oe_q, irq_oe_d;
    logic [NVW-1:0] nvc_q, nvc_d;
    rtcsa_snap_t snap_q, snap_d;
    logic [1:0] hit;

    // Link-domain state.
    rtcsa_lstate_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, mask_q, mask_d, srv_q, srv_d;
    logic [5:0] addr_q, addr_d;
    logic oe_q, oe_d, wel_q, wel_d, register_write_latch_q, register_write_latch_d, ok_q, ok_d;
    logic ctg_q, ctg_d, sreq_q, sreq_d, clr_q, clr_d, pend_q, pend_d;
    logic [1:0] clrm_q, clrm_d;
    rtcsa_bank_t stage_q, stage_d;
    rtcsa_commit_t msg_q, msg_d;

    // Event decodes from the synchronised stages.
    logic xedge, c_ev, s_ev, k_ev, rst_l, scl_r, scl_f, start, stop;
    logic nvb_l, nv_fall, snap_ready;
    assign xedge = xs_q[1] & ~xs_q[2];
    assign c_ev = cts_q[1] ^ cts_q[2];
    assign s_ev = sqs_q[1] ^ sqs_q[2];
    assign k_ev = cls_q[1] ^ cls_q[2];
    assign rst_l = lrst_q[1];
    assign scl_r = scl_q[1] & ~scl_q[2];
    assign scl_f = ~scl_q[1] & scl_q[2];
    assign start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
    assign nvb_l = nvs_q[1];
    assign nv_fall = nvs_q[2] & ~nvs_q[1];
    assign snap_ready = (sak_q[1] == sreq_q);

    // BCD increment of one byte; bits above the tens digit ride along.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // Last date of the month; BCD years divisible by four are leap years.
    function automatic logic [7:0] last_day(input logic [7:0] mo, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mo == MON_FEB) begin
            last_day = leap ? 8'h29 : 8'h28;
        end else if (mo == MON_APR || mo == MON_JUN || mo == MON_SEP || mo == MON_NOV) begin
            last_day = 8'h30;
        end else begin
            last_day = 8'h31;
        end
    endfunction

    // System-side synchronisers: crystal, backup flag and three link toggles.
    always_ff @(posedge i_clk_sys) begin
        xs_q <= {xs_q[1:0], i_xtal};
        bs_q <= {bs_q[0], i_on_backup};
        cts_q <= {cts_q[1:0], ctg_q};
        sqs_q <= {sqs_q[1:0], sreq_q};
        cls_q <= {cls_q[1:0], clr_q};
    end

    // Alarm compare on the settled time, one cycle after each tick.
    always_comb begin
        hit = 2'b00;
        for (int n = 0; n < 2; n++) begin
            logic any, eq;
            any = 1'b0;
            eq = 1'b1;
            for (int i = 0; i < ALARM_FIELDS; i++) begin
                if (al_q[n][i][ALARM_EN]) begin
                    any = 1'b1;
                    eq = eq & (al_q[n][i][6:0] == tm_q[i][6:0]);
                end
            end
            hit[n] = any & eq;
        end
    end

    // Timekeeping, alarms, commit and snapshot in the system domain.
    always_comb begin
        logic c;
        c = 1'b0;
        pre_d = pre_q;
        tm_d = tm_q;
        rtcf_d = rtcf_q;
        al_d = al_q;
        arm_d = arm_q;
        flag_d = flag_q;
        nvc_d = nvc_q;
        nvb_d = nvb_q;
        snap_d = snap_q;
        sack_d = sack_q;
        tick_d = 1'b0;
        if (xedge) begin
            if (pre_q == TICK_LAST) begin
                pre_d = '0;
                tick_d = 1'b1;
            end else begin
                pre_d = pre_q + 15'h0001;
            end
        end
        c = tick_d & ~rtcf_q;
        if (c) begin
            c = (tm_q[IDX_SEC] == BCD_59);
            tm_d[IDX_SEC] = c ? BCD_00 : bcd_inc(tm_q[IDX_SEC]);
        end
        if (c) begin
            c = (tm_q[IDX_MIN] == BCD_59);
            tm_d[IDX_MIN] = c ? BCD_00 : bcd_inc(tm_q[IDX_MIN]);
        end
        if (c) begin
            if (tm_q[IDX_HR][HR_MIL]) begin
                c = (tm_q[IDX_HR][5:0] == HR24_LAST);
                tm_d[IDX_HR] = c ? (tm_q[IDX_HR] & HR_FMT_MASK) : bcd_inc(tm_q[IDX_HR]);
            end else if (tm_q[IDX_HR][4:0] == HR12_TOP) begin
                c = 1'b0;
                tm_d[IDX_HR] = {tm_q[IDX_HR][7:5], HR12_FIRST};
            end else if (tm_q[IDX_HR][4:0] == HR12_PRE) begin
                c = tm_q[IDX_HR][HR_PM];
                tm_d[IDX_HR] = {tm_q[IDX_HR][7:6], ~tm_q[IDX_HR][HR_PM], HR12_TOP};
            end else begin
                c = 1'b0;
                tm_d[IDX_HR] = bcd_inc(tm_q[IDX_HR]);
            end
        end
        if (c) begin
            tm_d[IDX_WDAY] = (tm_q[IDX_WDAY] == WDAY_LAST) ? BCD_00 : bcd_inc(tm_q[IDX_WDAY]);
        end
        if (c) begin
            c = (tm_q[IDX_DATE] == last_day(tm_q[IDX_MON], tm_q[IDX_YEAR]));
            tm_d[IDX_DATE] = c ? BCD_01 : bcd_inc(tm_q[IDX_DATE]);
        end
        if (c) begin
            c = (tm_q[IDX_MON] == BCD_12);
            tm_d[IDX_MON] = c ? BCD_01 : bcd_inc(tm_q[IDX_MON]);
        end
        if (c) begin
            tm_d[IDX_YEAR] = (tm_q[IDX_YEAR] == BCD_99) ? BCD_00 : bcd_inc(tm_q[IDX_YEAR]);
        end
        if (c_ev) begin
            for (int i = 0; i < 8; i++) begin
                if (msg_q.mask[i]) begin
                    if (msg_q.sect == SEC_RTC) begin
                        tm_d[i] = msg_q.data[i];
                    end else begin
                        al_d[msg_q.sect[0]][i] = msg_q.data[i];
                    end
                end
            end
            if (msg_q.sect == SEC_RTC) begin
                rtcf_d = 1'b0;
            end else begin
                arm_d[msg_q.sect[0]] = 1'b1;
                nvb_d = 1'b1;
                nvc_d = NV_LAST;
            end
        end else if (nvb_q) begin
            if (nvc_q == '0) begin
                nvb_d = 1'b0;
            end else begin
                nvc_d = nvc_q - 1'b1;
            end
        end
        if (k_ev) begin
            flag_d = flag_q & ~clrm_q;
        end
        if (tick_q) begin
            for (int n = 0; n < 2; n++) begin
                if (hit[n] && arm_q[n]) begin
                    flag_d[n] = 1'b1;
                    arm_d[n] = i_alarm_repeat;
                end
            end
        end
        if (s_ev) begin
            snap_d.time_b = tm_q;
            snap_d.al0 = al_q[0];
            snap_d.al1 = al_q[1];
            snap_d.sr = '0;
            snap_d.sr[SR_BAT] = bs_q[1];
            snap_d.sr[SR_AL1] = flag_q[1];
            snap_d.sr[SR_AL0] = flag_q[0];
            snap_d.sr[SR_RTCF] = rtcf_q;
            sack_d = sqs_q[1];
        end
        irq_oe_d = i_irq_en & (|flag_d);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pre_q <= '0;
            tm_q <= RTC_RESET;
            rtcf_q <= 1'b1;
            al_q[0] <= '0;
            al_q[1] <= '0;
            arm_q <= 2'b00;
            flag_q <= 2'b00;
            nvc_q <= '0;
            nvb_q <= 1'b0;
            snap_q <= '0;
            sack_q <= 1'b0;
            tick_q <= 1'b0;
            irq_oe_q <= 1'b0;
            o_irq_o <= 1'b0;
        end else begin
            pre_q <= pre_d;
            tm_q <= tm_d;
            rtcf_q <= rtcf_d;
            al_q <= al_d;
            arm_q <= arm_d;
            flag_q <= flag_d;
            nvc_q <= nvc_d;
            nvb_q <= nvb_d;
            snap_q <= snap_d;
            sack_q <= sack_d;
            tick_q <= tick_d;
            irq_oe_q <= irq_oe_d;
            o_irq_o <= 1'b0;
        end
    end
    assign o_irq_oe = irq_oe_q;

    // Link-side synchronisers: reset, pins, busy level and snapshot ack.
    always_ff @(posedge i_clk_link) begin
        lrst_q <= {lrst_q[0], i_sys_rst};
        scl_q <= {scl_q[1:0], i_scl};
        sda_q <= {sda_q[1:0], i_sda_i};
        nvs_q <= {nvs_q[1:0], nvb_q};
        sak_q <= {sak_q[0], sack_q};
    end

    // Two-wire slave; the snapshot words are stable once the ack toggle returns.
    always_comb begin
        logic [7:0] rb;
        rtcsa_bank_t base;
        logic is_sr, allow;
        rb = 8'h00;
        base = snap_q.time_b;
        is_sr = (addr_q == SR_ADDR);
        allow = 1'b0;
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        addr_d = addr_q;
        oe_d = oe_q;
        wel_d = wel_q;
        register_write_latch_d = register_write_latch_q;
        ok_d = ok_q;
        mask_d = mask_q;
        srv_d = srv_q;
        stage_d = stage_q;
        msg_d = msg_q;
        ctg_d = ctg_q;
        sreq_d = sreq_q;
        clr_d = clr_q;
        clrm_d = clrm_q;
        pend_d = pend_q;
        if (addr_q[5:3] == SEC_AL0) begin
            base = snap_q.al0;
        end else if (addr_q[5:3] == SEC_AL1) begin
            base = snap_q.al1;
        end
        if (is_sr) begin
            rb = {snap_q.sr[7:3], register_write_latch_q, wel_q, snap_q.sr[SR_RTCF]};
        end else if (addr_q[5:3] == SEC_AL0 || addr_q[5:3] == SEC_AL1 || addr_q[5:3] == SEC_RTC) begin
            rb = base[addr_q[2:0]];
        end
        if (nv_fall) begin
            register_write_latch_d = 1'b0;
        end
        if (start) begin
            st_d = L_DEV;
            // The clock fall that closes the start wraps this to zero, so that fall is not counted as a bit.
            bit_d = '1;
            oe_d = 1'b0;
            ok_d = 1'b0;
            mask_d = '0;
            pend_d = 1'b0;
        end else if (stop) begin
            if (ok_q && st_q == L_WR) begin
                if (is_sr) begin
                    if (srv_q == SR_CLEAR) begin
                        wel_d = 1'b0;
                        register_write_latch_d = 1'b0;
                    end else if (srv_q == SR_SET_WEL) begin
                        wel_d = 1'b1;
                    end else if (srv_q == SR_SET_REGISTER_WRITE_LATCH && wel_q) begin
                        register_write_latch_d = 1'b1;
                    end
                end else begin
                    msg_d = '{sect: addr_q[5:3], mask: mask_q, data: stage_q};
                    ctg_d = ~ctg_q;
                end
            end
            st_d = L_IDLE;
            oe_d = 1'b0;
            ok_d = 1'b0;
            mask_d = '0;
        end else if (scl_r) begin
            if (bit_q < BIT_ACK && st_q != L_RD) begin
                sh_d = {sh_q[6:0], sda_q[1]};
            end else if (bit_q == BIT_ACK && st_q == L_RD && sda_q[1]) begin
                st_d = L_IGN;
            end
        end else if (scl_f) begin
            bit_d = bit_q + 4'h1;
            oe_d = 1'b0;
            if (bit_q == BIT_LAST) begin
                unique case (st_q)
                    L_DEV: begin
                        if (sh_q[7:1] == DEV_ADDR && !nvb_l) begin
                            oe_d = 1'b1;
                            st_d = sh_q[0] ? L_RDA : L_AHI;
                        end else begin
                            st_d = L_IGN;
                        end
                    end
                    L_AHI: begin
                        oe_d = (sh_q == 8'h00);
                        st_d = (sh_q == 8'h00) ? L_ALO : L_IGN;
                    end
                    L_ALO: begin
                        oe_d = (sh_q[7:6] == 2'b00);
                        addr_d = sh_q[5:0];
                        st_d = (sh_q[7:6] == 2'b00) ? L_WA : L_IGN;
                    end
                    L_WR: begin
                        allow = is_sr ? (mask_q == '0)
                              : (wel_q & register_write_latch_q & (addr_q[5:3] == SEC_AL0 || addr_q[5:3] == SEC_AL1
                                 || addr_q[5:3] == SEC_RTC));
                        if (allow) begin
                            stage_d = (mask_q == '0) ? base : stage_q;
                            stage_d[addr_q[2:0]] = sh_q;
                            mask_d[addr_q[2:0]] = 1'b1;
                            srv_d = sh_q;
                            oe_d = 1'b1;
                            ok_d = 1'b1;
                            addr_d = is_sr ? addr_q : {addr_q[5:3], addr_q[2:0] + 3'h1};
                        end else begin
                            ok_d = 1'b0;
                            st_d = L_IGN;
                        end
                    end
                    L_RD: begin
                        if (is_sr) begin
                            clrm_d = {snap_q.sr[SR_AL1], snap_q.sr[SR_AL0]};
                            clr_d = ~clr_q;
                            st_d = L_IGN;
                        end else begin
                            addr_d = {addr_q[5:3], addr_q[2:0] + 3'h1};
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (bit_q == BIT_ACK) begin
                bit_d = '0;
                if (st_q == L_RDA || st_q == L_WA) begin
                    sreq_d = ~sreq_q;
                end
                if (st_q == L_RDA || st_q == L_RD) begin
                    st_d = L_RD;
                    pend_d = 1'b1;
                end else if (st_q == L_WA) begin
                    st_d = L_WR;
                end
            end else if (st_q == L_RD) begin
                sh_d = {sh_q[6:0], 1'b0};
                oe_d = ~sh_q[6];
            end
        end else if (pend_q && snap_ready) begin
            sh_d = rb;
            oe_d = ~rb[7];
            pend_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk_link) begin
        if (rst_l) begin
            st_q <= L_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            addr_q <= '0;
            oe_q <= 1'b0;
            wel_q <= 1'b0;
            register_write_latch_q <= 1'b0;
            ok_q <= 1'b0;
            mask_q <= '0;
            srv_q <= '0;
            stage_q <= '0;
            msg_q <= '0;
            ctg_q <= 1'b0;
            sreq_q <= 1'b0;
            clr_q <= 1'b0;
            clrm_q <= 2'b00;
            pend_q <= 1'b0;
            o_sda_o <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            oe_q <= oe_d;
            wel_q <= wel_d;
            register_write_latch_q <= register_write_latch_d;
            ok_q <= ok_d;
            mask_q <= mask_d;
            srv_q <= srv_d;
            stage_q <= stage_d;
            msg_q <= msg_d;
            ctg_q <= ctg_d;
            sreq_q <= sreq_d;
            clr_q <= clr_d;
            clrm_q <= clrm_d;
            pend_q <= pend_d;
            o_sda_o <= 1'b0;
        end
    end
    assign o_sda_oe = oe_q;
endmodule

// ==== hdl/rtcsa_pkg.sv ====
// Constants and carrier types for the serial-access real-time clock core.
// Assumes a 10 MHz system clock, a sampled 32.768 kHz crystal timebase and
// an oversampling link clock for the two-wire bus.
package rtcsa_pkg;
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int XTAL_HZ = 32768;
    localparam logic [14:0] TICK_LAST = 15'(XTAL_HZ - 1);
    localparam int NV_WRITE_TIME_MS = 10;
    localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_MS * (SYS_CLK_HZ / 1000);
    // Bus address byte 1101111x selects the clock/control space.
    localparam logic [6:0] DEV_ADDR = 7'h6F;
    localparam logic [2:0] SEC_AL0 = 3'h0;
    localparam logic [2:0] SEC_AL1 = 3'h1;
    localparam logic [2:0] SEC_RTC = 3'h6;
    localparam logic [5:0] SR_ADDR = 6'h3F;
    localparam int IDX_SEC = 0;
    localparam int IDX_MIN = 1;
    localparam int IDX_HR = 2;
    localparam int IDX_DATE = 3;
    localparam int IDX_MON = 4;
    localparam int IDX_YEAR = 5;
    localparam int IDX_WDAY = 6;
    localparam int ALARM_FIELDS = 7;
    localparam int HR_MIL = 7;
    localparam int HR_PM = 5;
    localparam int SR_BAT = 7;
    localparam int SR_AL1 = 6;
    localparam int SR_AL0 = 5;
    localparam int SR_RTCF = 0;
    localparam int ALARM_EN = 7;
    localparam logic [7:0] SR_CLEAR = 8'h00;
    localparam logic [7:0] SR_SET_WEL = 8'h02;
    localparam logic [7:0] SR_SET_REGISTER_WRITE_LATCH = 8'h06;
    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] WDAY_LAST = 8'h06;
    localparam logic [5:0] HR24_LAST = 6'h23;
    localparam logic [4:0] HR12_TOP = 5'h12;
    localparam logic [4:0] HR12_PRE = 5'h11;
    localparam logic [4:0] HR12_FIRST = 5'h01;
    localparam logic [7:0] HR_FMT_MASK = 8'h80;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_NOV = 8'h11;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Byte 0 is seconds; byte 7 is a spare that is stored and read back.
    typedef logic [7:0][7:0] rtcsa_bank_t;
    // Power-on time: 12 AM in 12-hour form, 1st of month 1, year 00.
    localparam rtcsa_bank_t RTC_RESET = 64'h0000_0001_0112_0000;
    typedef struct packed {
        logic [2:0] sect;
        logic [7:0] mask;
        rtcsa_bank_t data;
    } rtcsa_commit_t;
    typedef struct packed {
        rtcsa_bank_t time_b;
        rtcsa_bank_t al0;
        rtcsa_bank_t al1;
        logic [7:0] sr;
    } rtcsa_snap_t;
    typedef enum logic [3:0] {
        L_IDLE, L_DEV, L_AHI, L_ALO, L_WA, L_WR, L_RDA, L_RD, L_IGN
    } rtcsa_lstate_t;
endpackage

// ==== sim/rtcsa_core_sva.sv ====
// Pin-level assertions for the serial clock core.
// Assumes it is bound to rtcsa_core; link-side pins are sampled on the system clock.
`timescale 1ns/100ps
module rtcsa_core_sva (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_irq_en,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic o_irq_o,
    input wire logic o_irq_oe
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);
    // A settled high bus-clock phase, in which the device must hold its data.
    sequence s_scl_high;
        i_scl [*6];
    endsequence
    sequence s_en_off;
        !i_irq_en ##1 !i_irq_en;
    endsequence
    a_sda_od_low: assert property (!o_sda_o) else $error("data pin drives high");
    a_irq_od_low: assert property (!o_irq_o) else $error("irq pin drives high");
    a_irq_needs_en: assert property (s_en_off |-> !o_irq_oe) else $error("irq while disabled");
    a_irq_cause: assert property ($rose(o_irq_oe) |-> $past(i_irq_en)) else $error("irq cause");
    a_irq_rst_off: assert property (disable iff (1'b0) i_sys_rst [*2] |-> !o_irq_oe) else $error("irq in reset");
    a_sda_rst_off: assert property (disable iff (1'b0) i_sys_rst [*8] |-> !o_sda_oe) else $error("sda in reset");
    a_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl) else $error("sda moved, clock high");
    a_sda_high_hold: assert property (s_scl_high |-> $stable(o_sda_oe)) else $error("sda unstable");
    a_ack_bounded: assert property ($rose(o_sda_oe) |-> ##[1:300] !o_sda_oe) else $error("sda held");
endmodule

bind rtcsa_core rtcsa_core_sva i_rtcsa_core_sva (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
    .i_irq_en(i_irq_en), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_irq_o(o_irq_o), .o_irq_oe(o_irq_oe));

// ==== sim/rtcsa_core_tb.sv ====
// Bench for the clock core: host model on the bus, random time values.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/100ps
module rtcsa_core_tb;
    logic clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, xtal = 1'b0, bat = 1'b0, en = 1'b0, rpt = 1'b0;
    logic ok = 1'b1, scl, lo, oe, irq_oe, n0, n1;
    logic [7:0] s, q;
    logic [31:0] sd = 32'hB05E9E76;
    int miscompares = 0, samples_checked = 0, cyc = 0;
    wire sda = !(lo | oe);
    wire irq_n = !irq_oe;
    always #50 clk_sys = ~clk_sys;
    always #62.5 clk_link = ~clk_link;
    // The crystal runs at half the system rate so that one second fits in the run.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        xtal <= ~xtal;
    end
    rtcsa_core #(.P_NV_WRITE_CYCLES(50)) i_rtcsa_core (.i_clk_sys(clk_sys), .i_sys_rst(rst), .i_clk_link(clk_link),
        .i_scl(scl), .i_sda_i(sda), .i_xtal(xtal), .i_on_backup(bat), .i_irq_en(en), .i_alarm_repeat(rpt),
        .o_sda_o(n0), .o_sda_oe(oe), .o_irq_o(n1), .o_irq_oe(irq_oe));
    rtcsa_host i_rtcsa_host (.i_clk_link(clk_link), .i_sda(sda), .o_scl(scl), .o_sda_lo(lo));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] inc(input logic [7:0] b);
        return (b[3:0] == 4'h9) ? {b[7:4] + 4'h1, 4'h0} : b + 8'h01;
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One transfer: address phase, then a data byte or a repeated-start read; ok collects acks.
    task automatic tr(input logic [7:0] dv, input logic [7:0] a, input logic [7:0] d, input logic rd);
        logic [8:0] r;
        logic [31:0] b;
        b = {dv, 8'h00, a, d};
        i_rtcsa_host.start();
        for (int i = 3; i >= (rd ? 1 : 0); i--) begin
            i_rtcsa_host.xb({b[i*8+:8], 1'b1}, r);
            ok &= !r[0];
        end
        if (rd) begin
            i_rtcsa_host.start();
            i_rtcsa_host.xb({8'hDF, 1'b1}, r);
            ok &= !r[0];
            i_rtcsa_host.xb(9'h1FF, r);
            q = r[8:1];
        end
        i_rtcsa_host.stop();
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        sd = xs(sd);
        s = 8'((sd % 59) / 10 * 16 + (sd % 59) % 10);
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        bat <= sd[8];
        rpt <= sd[9];
        en <= 1'b1;
        repeat (10000) @(posedge clk_sys);
        tr(8'hDE, 8'h3F, 8'h00, 1'b1);
        chk({ok, q}, {1'b1, bat, 7'h01});
        while (cyc < 50020) @(posedge clk_sys);
        tr(8'hDE, 8'h30, s, 1'b0);
        tr(8'hDE, 8'h30, 8'h00, 1'b1);
        chk({ok, q}, 9'h000);
        ok = 1'b1;
        tr(8'hD0, 8'h30, s, 1'b0);
        chk({ok, 8'h00}, 9'h000);
        $display("Refused writes done");
        ok = 1'b1;
        tr(8'hDE, 8'h3F, 8'h02, 1'b0);
        tr(8'hDE, 8'h3F, 8'h06, 1'b0);
        tr(8'hDE, 8'h00, 8'h80 | inc(s), 1'b0);
        repeat (100) @(posedge clk_sys);
        tr(8'hDE, 8'h3F, 8'h02, 1'b0);
        tr(8'hDE, 8'h3F, 8'h06, 1'b0);
        tr(8'hDE, 8'h30, s, 1'b0);
        tr(8'hDE, 8'h30, 8'h00, 1'b1);
        chk({ok, q}, {1'b1, s});
        tr(8'hDE, 8'h31, 8'h00, 1'b1);
        chk({ok, q}, 9'h100);
        tr(8'hDE, 8'h3F, 8'h00, 1'b1);
        chk({irq_n, q}, {1'b1, bat, 7'h06});
        tr(8'hDE, 8'h20, 8'h00, 1'b0);
        chk({ok, 8'h00}, 9'h000);
        $display("Time set done");
        while (cyc < 70000) @(posedge clk_sys);
        tr(8'hDE, 8'h30, 8'h00, 1'b1);
        chk({irq_n, q}, {1'b0, inc(s)});
        // enable gates the pin while the flag stays set.
        en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk({irq_n, 8'h00}, 9'h100);
        en <= 1'b1;
        for (int i = 0; i < 100 && irq_n; i++) @(posedge clk_sys);
        chk({irq_n, 8'h00}, 9'h000);
        // The status read clears the flag it reports, so the pin is released when the read ends.
        tr(8'hDE, 8'h3F, 8'h00, 1'b1);
        chk({irq_n, q}, {1'b1, bat, 7'h26});
        tr(8'hDE, 8'h3F, 8'h00, 1'b1);
        chk({irq_n, q}, {1'b1, bat, 7'h06});
        $display("Alarm done");
        wrap_up();
    end
endmodule

// ==== sim/rtcsa_host.sv ====
// Host model: two-wire bus master that clocks the bus and pulls data low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module rtcsa_host (
    input wire logic i_clk_link,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_lo
);
    initial begin
        o_scl = 1'b1;
        o_sda_lo = 1'b0;
    end
    // Seven link cycles per phase, well beyond the device's sync delay.
    task automatic ph(input logic c, input logic lo);
        @(posedge i_clk_link);
        o_scl <= c;
        o_sda_lo <= lo;
        repeat (6) @(posedge i_clk_link);
    endtask
    task automatic start();
        ph(o_scl, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
        ph(1'b0, 1'b1);
    endtask
    task automatic stop();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    // MSB first, data changes only while the clock is low.
    task automatic xb(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, !d[i]);
            ph(1'b1, !d[i]);
            q[i] = i_sda;
            ph(1'b0, !d[i]);
        end
    endtask
endmodule
